// >>> core/pbp_regs.sv
// partner base page status words behind a clause 45 management slave
`timescale 1ns/1ps

// How it works
// - words sit at 0x0205/0x0206/0x0207, device 0x07
// - low word read snapshots middle and high
// - middle/high reads return the snapshot
// - mid bit14 long reach; others reserved zero
// - mid bits 7,6,5: gigabit, full duplex, fast
// - mid bit4 master=1, slave=0
// - master bit taken from nonce bit 4
// - high bit14 energy efficient; others reserved zero
// - high bits 13,12: high level ability, request
// - high bit11 short reach half duplex
// - both words reset to zero
// - high level only if both able, one requests
// - low bit12 shows master forced or preferred
module pbp_regs (
    input  wire logic              i_core_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_mdc,
    input  wire logic              i_mdio,
    output logic                   o_mdio,
    output logic                   o_mdio_oe,
    input  wire logic [4:0]        i_phy_addr,
    input  wire logic              i_page_valid,
    input  wire pbp_pkg::pbp_page_t i_rx_page,
    input  wire logic              i_local_high_ability,
    input  wire logic              i_local_high_request,
    output logic                   o_tx_high_level
);
    import pbp_pkg::*;

    pbp_state_t  state_ff,     nxt_state;
    logic [5:0]  cnt_ff,       nxt_cnt;
    logic [15:0] shift_ff,     nxt_shift;
    logic [15:0] tx_ff,        nxt_tx;
    logic [15:0] addr_ff,      nxt_addr;
    pbp_op_t     op_ff,        nxt_op;
    logic        sel_ff,       nxt_sel;
    logic        mdc_q_ff,     nxt_mdc_q;
    logic        mdio_ff,      nxt_mdio;
    logic        mdio_oe_ff,   nxt_mdio_oe;
    logic [15:0] live_low_ff,  nxt_live_low;
    logic [15:0] live_mid_ff,  nxt_live_mid;
    logic [15:0] live_high_ff, nxt_live_high;
    logic [15:0] snap_mid_ff,  nxt_snap_mid;
    logic [15:0] snap_high_ff, nxt_snap_high;
    logic        tx_high_ff,   nxt_tx_high;

    logic        mdc_rise;
    logic [15:0] shifted;
    pbp_hdr_t    hdr;
    logic        is_read;
    logic [15:0] rx_mid;
    logic [15:0] rx_high;
    // strobes from the frame machine to the pointer and snapshot groups
    // live words follow the link; snapshots hold what the host last latched
    logic        snap_take;
    logic        frame_end;

    assign mdc_rise = i_mdc & ~mdc_q_ff;
    assign shifted  = {shift_ff[14:0], i_mdio};
    assign hdr      = pbp_hdr_t'(shifted[13:0]);
    assign is_read  = (op_ff == OP_READ) || (op_ff == OP_READ_INC);

    assign o_mdio          = mdio_ff;
    assign o_mdio_oe       = mdio_oe_ff;
    assign o_tx_high_level = tx_high_ff;

    // only documented fields pass; reserved bits stay zero
    always_comb begin
        rx_mid  = WORD_RESET;
        rx_high = WORD_RESET;
        rx_mid[MID_LONG_REACH_BIT]      = i_rx_page.mid[MID_LONG_REACH_BIT];
        rx_mid[MID_GIGABIT_BIT]         = i_rx_page.mid[MID_GIGABIT_BIT];
        rx_mid[MID_SR_FULL_DUPLEX_BIT]  = i_rx_page.mid[MID_SR_FULL_DUPLEX_BIT];
        rx_mid[MID_FAST_BIT]            = i_rx_page.mid[MID_FAST_BIT];
        rx_mid[MID_MASTER_BIT]          = i_rx_page[NONCE_LSB + NONCE_MASTER_BIT];
        rx_high[HIGH_EEE_BIT]           = i_rx_page.high[HIGH_EEE_BIT];
        rx_high[HIGH_LEVEL_ABILITY_BIT] = i_rx_page.high[HIGH_LEVEL_ABILITY_BIT];
        rx_high[HIGH_LEVEL_REQUEST_BIT] = i_rx_page.high[HIGH_LEVEL_REQUEST_BIT];
        rx_high[HIGH_SR_HALF_DUPLEX_BIT] = i_rx_page.high[HIGH_SR_HALF_DUPLEX_BIT];
    end

    always_comb begin
        nxt_state     = state_ff;
        nxt_cnt       = cnt_ff;
        nxt_shift     = shift_ff;
        nxt_tx        = tx_ff;
        nxt_op        = op_ff;
        nxt_sel       = sel_ff;
        nxt_mdio      = mdio_ff;
        nxt_mdio_oe   = mdio_oe_ff;
        snap_take     = 1'b0;
        frame_end     = 1'b0;

        // every frame is counted through, selected or not, so the
        // next preamble is found in step with the host

        if (mdc_rise) begin
            unique case (state_ff)
                ST_PREAMBLE: begin
                    // a zero before 32 ones restarts the count; that frame is ignored
                    if (i_mdio) begin
                        nxt_cnt = (cnt_ff == PREAMBLE_ONES) ? cnt_ff : cnt_ff + 6'h01;
                    end else if (cnt_ff == PREAMBLE_ONES) begin
                        nxt_state = ST_HEADER;
                        nxt_cnt   = 6'h01;
                        nxt_shift = 16'h0000;
                    end else begin
                        nxt_cnt = 6'h00;
                    end
                end
                ST_HEADER: begin
                    nxt_shift = shifted;
                    nxt_cnt   = cnt_ff + 6'h01;
                    if (cnt_ff == HEADER_LAST) begin
                        nxt_state = ST_TURN;
                        nxt_cnt   = 6'h00;
                        nxt_op    = hdr.op;
                        nxt_sel   = (hdr.start == 2'b00) && (hdr.port_addr == i_phy_addr)
                                  && (hdr.dev_addr == DEV_AUTONEG);
                        nxt_tx    = WORD_RESET;
                        if (nxt_sel && (hdr.op == OP_READ || hdr.op == OP_READ_INC)) begin
                            unique case (addr_ff)
                                ADDR_LOW_WORD: begin
                                    nxt_tx    = live_low_ff;
                                    snap_take = 1'b1;
                                end
                                ADDR_MID_WORD:  nxt_tx = snap_mid_ff;
                                ADDR_HIGH_WORD: nxt_tx = snap_high_ff;
                                default:        nxt_tx = WORD_RESET;
                            endcase
                        end
                    end
                end
                ST_TURN: begin
                    nxt_cnt = cnt_ff + 6'h01;
                    if (cnt_ff != TURN_LAST) begin
                        // second turnaround bit is driven low by the device
                        if (sel_ff && is_read) begin
                            nxt_mdio_oe = 1'b1;
                            nxt_mdio    = 1'b0;
                        end
                    end else begin
                        nxt_state = ST_DATA;
                        nxt_cnt   = 6'h00;
                        if (sel_ff && is_read) begin
                            nxt_mdio = tx_ff[15];
                            nxt_tx   = {tx_ff[14:0], 1'b0};
                        end
                    end
                end
                ST_DATA: begin
                    nxt_shift = shifted;
                    nxt_cnt   = cnt_ff + 6'h01;
                    if (sel_ff && is_read && cnt_ff != DATA_LAST) begin
                        nxt_mdio = tx_ff[15];
                        nxt_tx   = {tx_ff[14:0], 1'b0};
                    end
                    if (cnt_ff == DATA_LAST) begin
                        // a new preamble is required before the next frame
                        nxt_state   = ST_PREAMBLE;
                        nxt_cnt     = 6'h00;
                        nxt_mdio_oe = 1'b0;
                        nxt_mdio    = 1'b0;
                        frame_end   = sel_ff;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            state_ff     <= ST_PREAMBLE;
            cnt_ff       <= 6'h00;
            shift_ff     <= 16'h0000;
            op_ff        <= OP_ADDRESS;
            sel_ff       <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            shift_ff     <= nxt_shift;
            op_ff        <= nxt_op;
            sel_ff       <= nxt_sel;
        end
    end

    // read data serializer, registered so the pin never glitches between mdc edges
    // the line is released at the last data rise, ready for the next preamble
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            tx_ff        <= WORD_RESET;
            mdio_ff      <= 1'b0;
            mdio_oe_ff   <= 1'b0;
        end else begin
            tx_ff        <= nxt_tx;
            mdio_ff      <= nxt_mdio;
            mdio_oe_ff   <= nxt_mdio_oe;
        end
    end

    // previous sample resets low, the idle level of the pin, so no false rise follows reset
    // mdc must stay at least one core cycle in each phase to be seen
    always_comb begin
        nxt_mdc_q = i_mdc;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            mdc_q_ff <= 1'b0;
        end else begin
            mdc_q_ff <= nxt_mdc_q;
        end
    end

    // live copy follows every received page; the host sees middle and high only via snapshot, low directly
    // low word keeps every bit, the force flag among them
    always_comb begin
        nxt_live_low  = live_low_ff;
        nxt_live_mid  = live_mid_ff;
        nxt_live_high = live_high_ff;
        if (i_page_valid) begin
            nxt_live_low  = i_rx_page.low;
            nxt_live_mid  = rx_mid;
            nxt_live_high = rx_high;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            live_low_ff  <= WORD_RESET;
            live_mid_ff  <= WORD_RESET;
            live_high_ff <= WORD_RESET;
        end else begin
            live_low_ff  <= nxt_live_low;
            live_mid_ff  <= nxt_live_mid;
            live_high_ff <= nxt_live_high;
        end
    end

    // snapshot copies the live words at the low word read
    // a page landing on that same edge reaches only the live copy; the next low read takes it
    always_comb begin
        nxt_snap_mid  = snap_mid_ff;
        nxt_snap_high = snap_high_ff;
        if (snap_take) begin
            nxt_snap_mid  = live_mid_ff;
            nxt_snap_high = live_high_ff;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            snap_mid_ff  <= WORD_RESET;
            snap_high_ff <= WORD_RESET;
        end else begin
            snap_mid_ff  <= nxt_snap_mid;
            snap_high_ff <= nxt_snap_high;
        end
    end

    // pointer moves only when a selected frame ends; a write leaves it where it was
    // read-increment steps past the word just sent
    always_comb begin
        nxt_addr = addr_ff;
        if (frame_end) begin
            unique case (op_ff)
                OP_ADDRESS:  nxt_addr = shifted;
                OP_READ_INC: nxt_addr = addr_ff + 16'h0001;
                OP_WRITE:    nxt_addr = addr_ff;
                OP_READ:     nxt_addr = addr_ff;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            addr_ff <= ADDR_RESET;
        end else begin
            addr_ff <= nxt_addr;
        end
    end

    // level follows live partner bits, so it tracks the link, not the host's last read
    // both ends able, and at least one asking for it
    always_comb begin
        nxt_tx_high = i_local_high_ability & live_high_ff[HIGH_LEVEL_ABILITY_BIT]
                    & (i_local_high_request | live_high_ff[HIGH_LEVEL_REQUEST_BIT]);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            tx_high_ff <= 1'b0;
        end else begin
            tx_high_ff <= nxt_tx_high;
        end
    end

endmodule

// >>> core/pbp_pkg.sv
// constants and types for the partner base page ability registers
package pbp_pkg;

    // management device and register addresses
    localparam logic [4:0]  DEV_AUTONEG      = 5'h07;
    localparam logic [15:0] ADDR_LOW_WORD    = 16'h0205;
    localparam logic [15:0] ADDR_MID_WORD    = 16'h0206;
    localparam logic [15:0] ADDR_HIGH_WORD   = 16'h0207;
    localparam logic [15:0] WORD_RESET       = 16'h0000;
    localparam logic [15:0] ADDR_RESET       = 16'h0000;

    // middle word fields
    localparam int MID_LONG_REACH_BIT        = 14;
    localparam int MID_GIGABIT_BIT           = 7;
    localparam int MID_SR_FULL_DUPLEX_BIT    = 6;
    localparam int MID_FAST_BIT              = 5;
    localparam int MID_MASTER_BIT            = 4;

    // high word fields
    localparam int HIGH_EEE_BIT              = 14;
    localparam int HIGH_LEVEL_ABILITY_BIT    = 13;
    localparam int HIGH_LEVEL_REQUEST_BIT    = 12;
    localparam int HIGH_SR_HALF_DUPLEX_BIT   = 11;

    // low word field and nonce position inside the 48-bit page
    localparam int LOW_ROLE_FORCED_BIT       = 12;
    localparam int NONCE_LSB                 = 16;
    localparam int NONCE_MASTER_BIT          = 4;

    // management frame timing, in management clock periods
    localparam logic [5:0] PREAMBLE_ONES     = 6'h20;
    localparam logic [5:0] HEADER_LAST       = 6'h0D;
    localparam logic [5:0] TURN_LAST         = 6'h01;
    localparam logic [5:0] DATA_LAST         = 6'h0F;

    typedef enum logic [1:0] {
        OP_ADDRESS  = 2'b00,
        OP_WRITE    = 2'b01,
        OP_READ_INC = 2'b10,
        OP_READ     = 2'b11
    } pbp_op_t;

    typedef enum logic [1:0] {
        ST_PREAMBLE = 2'b00,
        ST_HEADER   = 2'b01,
        ST_TURN     = 2'b10,
        ST_DATA     = 2'b11
    } pbp_state_t;

    // frame header after the preamble: start, opcode, port and device address
    typedef struct packed {
        logic [1:0] start;
        pbp_op_t    op;
        logic [4:0] port_addr;
        logic [4:0] dev_addr;
    } pbp_hdr_t;

    // received base page, bits 47 down to 0
    typedef struct packed {
        logic [15:0] high;
        logic [15:0] mid;
        logic [15:0] low;
    } pbp_page_t;

endpackage

// >>> dv/pbp_regs_chk.sv
// port assertions for the partner base page registers
`timescale 1ns/1ps
module pbp_regs_chk (
    input  wire logic               i_core_clk,
    input  wire logic               i_resetn,
    input  wire logic               i_mdc,
    input  wire logic               i_mdio,
    input  wire logic               o_mdio,
    input  wire logic               o_mdio_oe,
    input  wire logic [4:0]         i_phy_addr,
    input  wire logic               i_page_valid,
    input  wire pbp_pkg::pbp_page_t i_rx_page,
    input  wire logic               i_local_high_ability,
    input  wire logic               i_local_high_request,
    input  wire logic               o_tx_high_level
);
    import pbp_pkg::*;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_rise_seen;
        $past(i_mdc) && !$past(i_mdc, 2);
    endsequence
    sequence s_page_settled;
        i_page_valid ##1 (!i_page_valid && $stable(i_local_high_ability) && $stable(i_local_high_request)) [*2];
    endsequence
    property p_reset_quiet;
        $rose(i_resetn) |-> !o_mdio_oe && !o_mdio && !o_tx_high_level;
    endproperty
    property p_oe_on_rise;
        $rose(o_mdio_oe) |-> s_rise_seen;
    endproperty
    property p_oe_off_rise;
        $fell(o_mdio_oe) |-> s_rise_seen;
    endproperty
    property p_data_stands;
        o_mdio_oe && $past(o_mdio_oe) && $changed(o_mdio) |-> s_rise_seen;
    endproperty
    property p_ta_low;
        $rose(o_mdio_oe) |-> !o_mdio;
    endproperty
    property p_ta_released;
        $rose(o_mdio_oe) |-> $past(i_mdio);
    endproperty
    property p_drive_hold;
        $rose(o_mdio_oe) |-> o_mdio_oe [*8];
    endproperty
    property p_level;
        s_page_settled |=> o_tx_high_level == ($past(i_local_high_ability, 3) & $past(i_rx_page.high[13], 3)
            & ($past(i_local_high_request, 3) | $past(i_rx_page.high[12], 3)));
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
    a_oe_on_rise: assert property (p_oe_on_rise) else $error("drive began off a clock rise");
    a_oe_off_rise: assert property (p_oe_off_rise) else $error("drive ended off a clock rise");
    a_data_stands: assert property (p_data_stands) else $error("read data moved between rises");
    a_ta_low: assert property (p_ta_low) else $error("turnaround bit not low");
    a_ta_released: assert property (p_ta_released) else $error("drive while host held line");
    a_drive_hold: assert property (p_drive_hold) else $error("read drive too short");
    a_level: assert property (p_level) else $error("transmit level wrong");
endmodule

bind pbp_regs pbp_regs_chk pbp_regs_chk_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_mdc(i_mdc),
    .i_mdio(i_mdio), .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe), .i_phy_addr(i_phy_addr),
    .i_page_valid(i_page_valid), .i_rx_page(i_rx_page), .i_local_high_ability(i_local_high_ability),
    .i_local_high_request(i_local_high_request), .o_tx_high_level(o_tx_high_level));

// >>> dv/pbp_host_model.sv
// management host model issuing clause 45 frames
`timescale 1ns/1ps
module pbp_host_model (
    input  wire logic i_core_clk,
    input  wire logic i_dev_mdio,
    input  wire logic i_dev_oe,
    output logic      o_mdc,
    output logic      o_line
);
    logic host_oe;
    logic host_bit;
    // released line floats to its pull-up
    assign o_line = i_dev_oe ? i_dev_mdio : (host_oe ? host_bit : 1'b1);
    initial begin
        o_mdc = 1'b0;
        host_oe = 1'b0;
        host_bit = 1'b1;
    end
    // two core cycles per phase, twice the shortest phase the slave still sees
    task automatic clk_bit(input logic oe, input logic b, output logic s);
        host_oe <= oe;
        host_bit <= b;
        o_mdc <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        s = o_line;
        o_mdc <= 1'b1;
        repeat (2) @(posedge i_core_clk);
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] prt, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [13:0] hdr;
        logic        drv;
        logic        s;
        hdr = {2'b00, op, prt, pbp_pkg::DEV_AUTONEG};
        drv = !op[1];
        for (int i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
        clk_bit(drv, 1'b1, s);
        clk_bit(drv, 1'b0, s);
        for (int i = 15; i >= 0; i--) clk_bit(drv, wd[i], rd[i]);
        host_oe <= 1'b0;
        o_mdc <= 1'b0;
        repeat (2) @(posedge i_core_clk);
    endtask
endmodule

// >>> dv/pbp_regs_bench.sv
// self-checking bench for the partner base page registers
`timescale 1ns/1ps
module pbp_regs_bench;
    import pbp_pkg::*;
    localparam logic [4:0] PRT = 5'h03;
    logic      clk;
    logic      rstn;
    logic      mdc;
    logic      line;
    logic      dev_mdio;
    logic      dev_oe;
    logic      pv;
    pbp_page_t page;
    logic      labl;
    logic      lreq;
    logic      tx_lvl;
    int        err_count;
    int        tests_run;
    int        cyc;
    pbp_regs pbp_regs_i (.i_core_clk(clk), .i_resetn(rstn), .i_mdc(mdc), .i_mdio(line), .o_mdio(dev_mdio),
        .o_mdio_oe(dev_oe), .i_phy_addr(PRT), .i_page_valid(pv), .i_rx_page(page),
        .i_local_high_ability(labl), .i_local_high_request(lreq), .o_tx_high_level(tx_lvl));
    pbp_host_model pbp_host_model_i (.i_core_clk(clk), .i_dev_mdio(dev_mdio), .i_dev_oe(dev_oe),
        .o_mdc(mdc), .o_line(line));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic summarize();
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // whole run needs under ten thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        logic [15:0] x;
        pbp_host_model_i.frame(2'b00, PRT, a, x);
        pbp_host_model_i.frame(2'b11, PRT, 16'h0000, d);
    endtask
    task automatic put(input pbp_page_t p);
        page <= p;
        pv <= 1'b1;
        @(posedge clk);
        pv <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_reset_vals();
        logic [15:0] d;
        rd(ADDR_MID_WORD, d);
        chk(d, 16'h0000);
        rd(ADDR_HIGH_WORD, d);
        chk(d, 16'h0000);
        rd(16'h0300, d);
        chk(d, 16'h0000);
    endtask
    task automatic t_snapshot();
        logic [15:0] d;
        put({16'hFFFF, 16'hFFFF, 16'h1001});
        rd(ADDR_MID_WORD, d);
        chk(d, 16'h0000);
        rd(ADDR_LOW_WORD, d);
        chk(d, 16'h1001);
        rd(ADDR_MID_WORD, d);
        chk(d, 16'h40F0);
        rd(ADDR_HIGH_WORD, d);
        chk(d, 16'h7800);
        put({16'h0800, 16'h0010, 16'h0000});
        rd(ADDR_MID_WORD, d);
        chk(d, 16'h40F0);
        rd(ADDR_LOW_WORD, d);
        chk(d, 16'h0000);
        rd(ADDR_MID_WORD, d);
        chk(d, 16'h0010);
    endtask
    task automatic t_refusals();
        logic [15:0] d;
        pbp_host_model_i.frame(2'b00, PRT, ADDR_MID_WORD, d);
        pbp_host_model_i.frame(2'b01, PRT, 16'hFFFF, d);
        rd(ADDR_MID_WORD, d);
        chk(d, 16'h0010);
        pbp_host_model_i.frame(2'b11, 5'h04, 16'h0000, d);
        chk(d, 16'hFFFF);
        pbp_host_model_i.frame(2'b10, PRT, 16'h0000, d);
        chk(d, 16'h0010);
        pbp_host_model_i.frame(2'b11, PRT, 16'h0000, d);
        chk(d, 16'h0800);
    endtask
    task automatic t_level();
        logic [3:0] v;
        for (int i = 0; i < 16; i++) begin
            v = i[3:0];
            labl <= v[3];
            lreq <= v[2];
            put({2'b00, v[1:0], 12'h000, 32'h0});
            chk({15'h0, tx_lvl}, {15'h0, v[3] & v[1] & (v[2] | v[0])});
        end
    endtask
    initial begin
        rstn = 1'b0;
        pv = 1'b0;
        page = '0;
        labl = 1'b0;
        lreq = 1'b0;
        err_count = 0;
        tests_run = 0;
        cyc = 0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset_vals();
        t_snapshot();
        t_refusals();
        t_level();
        summarize();
    end
endmodule
